// ==== logic/phylr_regs.sv ====
// Link state, PRBS seed and autonomous link reliability register bank of
// one switch port, reached over APB.
// Assumes the port core supplies the state machine state and event pulses
// synchronous to clk_i; rst_i is the fundamental reset, hot_reset_i the
// non-fundamental one.
//
// How it works
// - Status bit mirrors partner's upconfigure capability, read only
// - Five-bit read-only field tracks current link state, reset zero
// - State field carries the port state machine encodings unchanged
// - Writing one to full retrain sends the state machine to Detect
// - Full retrain bit always reads back as zero
// - Write completion is returned before the retrain pulse leaves
// - Sticky writable 16-bit PRBS seed, reset 0xffff, drives crosslink PRBS
// - Any change of seed reloads the PRBS generator from the seed
// - Sticky enable bit, reset zero, gates the reliability mechanism
// - Error type zero counts LCRC failures on received packets
// - Error type one counts L0 to Recovery link state errors
// - Only Recovery entries this port initiates are counted
// - Enabled, count at or above threshold sets sticky unreliable flag
// - Counter saturates; clears on retrain, link down, enable rising
`timescale 1ns/100ps

module phylr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hot_reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Port core side
  input wire logic partner_upconfig_capable_i,
  input wire logic [4:0] link_fsm_state_i,
  input wire phylr_pkg::phylr_event_type link_event_i,
  input wire logic prbs_advance_i,
  output logic full_retrain_request_o,
  output logic [15:0] prbs_state_o,
  output logic prbs_bit_o,
  output logic reliability_enable_o,
  output logic reliability_error_type_o,
  output logic unreliable_link_flag_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic partner_upconfig_q;
  logic [4:0] link_fsm_state_q;
  logic [31:0] prdata_q;
  logic full_retrain_q;
  logic [15:0] prbs_seed_q;
  logic [15:0] prbs_seed_d;
  logic [15:0] prbs_lfsr_q;
  logic [15:0] prbs_lfsr_d;
  logic rel_enable_q;
  logic rel_enable_d;
  phylr_pkg::phylr_err_mode_type err_mode_q;
  phylr_pkg::phylr_err_mode_type err_mode_d;
  logic [7:0] threshold_q;
  logic [7:0] threshold_d;
  logic [7:0] err_count_q;
  logic [7:0] err_count_d;
  logic unreliable_q;
  logic unreliable_d;
  logic [phylr_pkg::IRQ_BITS-1:0] irq_status_q;
  logic [phylr_pkg::IRQ_BITS-1:0] irq_status_d;
  logic [phylr_pkg::IRQ_BITS-1:0] irq_mask_q;
  logic [phylr_pkg::IRQ_BITS-1:0] irq_mask_d;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup_phase = psel_i & ~penable_i;
  wire access_done = psel_i & penable_i;
  wire wr_done = access_done & pwrite_i;
  wire rd_done = access_done & ~pwrite_i;

  wire hit_partner = paddr_i == phylr_pkg::OFS_PARTNER_STATUS;
  wire hit_state = paddr_i == phylr_pkg::OFS_LINK_STATE;
  wire hit_seed = paddr_i == phylr_pkg::OFS_PRBS_SEED;
  wire hit_control = paddr_i == phylr_pkg::OFS_REL_CONTROL;
  wire hit_status = paddr_i == phylr_pkg::OFS_REL_STATUS;
  wire hit_threshold = paddr_i == phylr_pkg::OFS_REL_THRESHOLD;
  wire hit_count = paddr_i == phylr_pkg::OFS_REL_COUNT;
  wire hit_irq_status = paddr_i == phylr_pkg::OFS_IRQ_STATUS;
  wire hit_irq_mask = paddr_i == phylr_pkg::OFS_IRQ_MASK;
  wire hit_any = hit_partner | hit_state | hit_seed | hit_control |
                 hit_status | hit_threshold | hit_count | hit_irq_status |
                 hit_irq_mask;

  wire wr_state = wr_done & hit_state;
  wire wr_seed = wr_done & hit_seed;
  wire wr_control = wr_done & hit_control;
  wire wr_status = wr_done & hit_status;
  wire wr_threshold = wr_done & hit_threshold;
  wire wr_irq_mask = wr_done & hit_irq_mask;
  wire rd_irq_status = rd_done & hit_irq_status;

  // Data is latched in the setup cycle so prdata_o comes from a flip-flop
  // while the slave still answers without wait states.
  assign pready_o = 1'b1;
  assign pslverr_o = access_done & ~hit_any;
  assign prdata_o = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_partner;
  logic [31:0] rd_state;
  logic [31:0] rd_control;
  logic [31:0] rd_status;

  always_comb begin
    rd_partner = 32'h0000_0000;
    rd_partner[phylr_pkg::POS_UPCONFIG] = partner_upconfig_q;
    rd_state = {27'h000_0000, link_fsm_state_q};
    rd_state[phylr_pkg::POS_FULL_RETRAIN] = 1'b0;
    rd_control = 32'h0000_0000;
    rd_control[phylr_pkg::POS_REL_ENABLE] = rel_enable_q;
    rd_control[phylr_pkg::POS_REL_ERR_TYPE] = err_mode_q;
    rd_status = 32'h0000_0000;
    rd_status[phylr_pkg::POS_UNRELIABLE] = unreliable_q;
  end

  wire [31:0] seed_word = {16'h0000, prbs_seed_q};
  wire [31:0] threshold_word = {24'h00_0000, threshold_q};
  wire [31:0] count_word = {24'h00_0000, err_count_q};
  wire [31:0] irq_status_word = {29'h0000_0000, irq_status_q};
  wire [31:0] irq_mask_word = {29'h0000_0000, irq_mask_q};

  wire [31:0] rd_mux =
    hit_partner ? rd_partner :
    hit_state ? rd_state :
    hit_seed ? seed_word :
    hit_control ? rd_control :
    hit_status ? rd_status :
    hit_threshold ? threshold_word :
    hit_count ? count_word :
    hit_irq_status ? irq_status_word :
    hit_irq_mask ? irq_mask_word :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Link state mirror
  // The state code is passed through untouched so every encoding,
  // including the reserved ones, reads as the state machine holds it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      partner_upconfig_q <= 1'b0;
    end else begin
      partner_upconfig_q <= partner_upconfig_capable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_fsm_state_q <= phylr_pkg::RST_LINK_STATE;
    end else begin
      link_fsm_state_q <= link_fsm_state_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite_i) begin
      prdata_q <= rd_mux;
    end else if (access_done) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Full retrain
  // The pulse leaves one cycle after the completing edge, so the APB
  // answer is already back with the requester when the link drops.
  wire retrain_written = wr_state & pwdata_i[phylr_pkg::POS_FULL_RETRAIN];

  always_ff @(posedge clk_i) begin
    if (rst_i | hot_reset_i) begin
      full_retrain_q <= 1'b0;
    end else begin
      full_retrain_q <= retrain_written;
    end
  end

  assign full_retrain_request_o = full_retrain_q;

  ////////////////////////////////////////////////////////////////////////////
  // PRBS seed and generator
  wire seed_changed = wr_seed & (pwdata_i[15:0] != prbs_seed_q);
  wire prbs_feedback = ^(prbs_lfsr_q & phylr_pkg::PRBS_TAPS) ^ prbs_lfsr_q[15];

  assign prbs_seed_d = wr_seed ? pwdata_i[15:0] : prbs_seed_q;
  assign prbs_lfsr_d =
    seed_changed ? pwdata_i[15:0] :
    prbs_advance_i ? {prbs_lfsr_q[14:0], prbs_feedback} :
    prbs_lfsr_q;

  // Sticky: only the fundamental reset touches the seed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prbs_seed_q <= phylr_pkg::RST_PRBS_SEED;
    end else begin
      prbs_seed_q <= prbs_seed_d;
    end
  end

  // The generator is kept with its seed, so a hot reset leaves the
  // crosslink sequence running where it was.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prbs_lfsr_q <= phylr_pkg::RST_PRBS_SEED;
    end else begin
      prbs_lfsr_q <= prbs_lfsr_d;
    end
  end

  assign prbs_state_o = prbs_lfsr_q;
  assign prbs_bit_o = prbs_lfsr_q[15];

  ////////////////////////////////////////////////////////////////////////////
  // Reliability control, sticky
  assign rel_enable_d =
    wr_control ? pwdata_i[phylr_pkg::POS_REL_ENABLE] : rel_enable_q;
  assign err_mode_d = wr_control ?
    phylr_pkg::phylr_err_mode_type'(pwdata_i[phylr_pkg::POS_REL_ERR_TYPE]) :
    err_mode_q;
  assign threshold_d = wr_threshold ? pwdata_i[7:0] : threshold_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_enable_q <= 1'b0;
    end else begin
      rel_enable_q <= rel_enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_mode_q <= phylr_pkg::phylr_err_bit;
    end else begin
      err_mode_q <= err_mode_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_q <= phylr_pkg::RST_THRESHOLD;
    end else begin
      threshold_q <= threshold_d;
    end
  end

  assign reliability_enable_o = rel_enable_q;
  assign reliability_error_type_o = err_mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Error counter
  // Link-partner initiated Recovery entries carry self_initiated low and
  // are dropped here; the core cannot tell their cause anyway.
  wire state_error = link_event_i.recovery_entry &
                     link_event_i.self_initiated;
  wire err_hit = (err_mode_q == phylr_pkg::phylr_err_bit) ?
                 link_event_i.lcrc_error :
                 state_error;
  wire enable_rise = rel_enable_d & ~rel_enable_q;
  wire count_clear = retrain_written | link_event_i.retrain_req |
                     link_event_i.dl_down | enable_rise;
  wire count_full = err_count_q == phylr_pkg::COUNT_MAX;

  // Counting continues while the mechanism is disabled; only the flag
  // is gated by the enable.
  assign err_count_d =
    count_clear ? phylr_pkg::RST_COUNT :
    (err_hit & ~count_full) ? err_count_q + 8'h01 :
    err_count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i | hot_reset_i) begin
      err_count_q <= phylr_pkg::RST_COUNT;
    end else begin
      err_count_q <= err_count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unreliable link flag, sticky, software clears by writing one
  wire unreliable_set = rel_enable_q & (err_count_q >= threshold_q);
  wire unreliable_clr = wr_status & pwdata_i[phylr_pkg::POS_UNRELIABLE];

  // Set wins over a clear in the same cycle
  assign unreliable_d = unreliable_set | (unreliable_q & ~unreliable_clr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unreliable_q <= 1'b0;
    end else begin
      unreliable_q <= unreliable_d;
    end
  end

  assign unreliable_link_flag_o = unreliable_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [phylr_pkg::IRQ_BITS-1:0] irq_events;

  always_comb begin
    irq_events = '0;
    irq_events[phylr_pkg::IRQ_UNRELIABLE] = unreliable_set & ~unreliable_q;
    irq_events[phylr_pkg::IRQ_LINK_DOWN] = link_event_i.dl_down;
    irq_events[phylr_pkg::IRQ_RETRAIN] = full_retrain_q;
  end

  // A read clears only the bits it returned, so an event landing in the
  // setup cycle, after the read data was latched, is not lost.
  wire [phylr_pkg::IRQ_BITS-1:0] irq_reported =
    rd_irq_status ? prdata_q[phylr_pkg::IRQ_BITS-1:0] : '0;
  assign irq_status_d = irq_events | (irq_status_q & ~irq_reported);
  assign irq_mask_d = wr_irq_mask ?
                      pwdata_i[phylr_pkg::IRQ_BITS-1:0] : irq_mask_q;

  always_ff @(posedge clk_i) begin
    if (rst_i | hot_reset_i) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i | hot_reset_i) begin
      irq_mask_q <= '0;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

endmodule

// ==== common/phylr_pkg.sv ====
// Constants and carrier types for the port physical-layer link state and
// link reliability register bank.
// Assumes a 32-bit APB with byte addresses in the low 12 bits.
package phylr_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_PARTNER_STATUS = 12'h538;
  localparam logic [11:0] OFS_LINK_STATE = 12'h540;
  localparam logic [11:0] OFS_PRBS_SEED = 12'h55c;
  localparam logic [11:0] OFS_REL_CONTROL = 12'h560;
  localparam logic [11:0] OFS_REL_STATUS = 12'h564;
  localparam logic [11:0] OFS_REL_THRESHOLD = 12'h568;
  localparam logic [11:0] OFS_REL_COUNT = 12'h56c;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h570;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h574;

  // Field positions
  localparam int POS_UPCONFIG = 16;
  localparam int POS_FULL_RETRAIN = 31;
  localparam int POS_REL_ENABLE = 0;
  localparam int POS_REL_ERR_TYPE = 1;
  localparam int POS_UNRELIABLE = 0;

  // Interrupt status bit positions
  localparam int IRQ_UNRELIABLE = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_RETRAIN = 2;
  localparam int IRQ_BITS = 3;

  // Values after reset
  localparam logic [4:0] RST_LINK_STATE = 5'h00;
  localparam logic [15:0] RST_PRBS_SEED = 16'hffff;
  localparam logic [7:0] RST_THRESHOLD = 8'hff;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // Link state machine encodings used by the block
  localparam logic [4:0] LS_XMIT_EIOS = 5'h00;
  localparam logic [4:0] LS_DET_QUIET = 5'h02;
  localparam logic [4:0] LS_L0 = 5'h14;
  localparam logic [4:0] LS_L0S = 5'h15;
  localparam logic [4:0] LS_DISABLE = 5'h1a;
  localparam logic [4:0] LS_HOT_RST = 5'h1b;
  localparam logic [4:0] LS_LPBK_ENTRY = 5'h1c;

  // PRBS polynomial taps x^16 + x^5 + x^4 + x^3 + 1
  localparam logic [15:0] PRBS_TAPS = 16'h0038;

  // Error type selection
  typedef enum logic {
    phylr_err_bit,
    phylr_err_link_state
  } phylr_err_mode_type;

  // Link events reported by the port core, one-cycle pulses
  typedef struct packed {
    logic lcrc_error;
    logic recovery_entry;
    logic self_initiated;
    logic dl_down;
    logic retrain_req;
  } phylr_event_type;

endpackage

// ==== sim/phylr_core_model.sv ====
// Port core stand-in: link state, partner capability and event pulses.
// Assumes the bench calls its tasks; it drives only after rising edges.
`timescale 1ns/100ps
module phylr_core_model (
  input wire logic clk_i,
  input wire logic full_retrain_request_i,
  output logic partner_upconfig_capable_o,
  output logic [4:0] link_fsm_state_o,
  output phylr_pkg::phylr_event_type link_event_o
);
  initial begin
    partner_upconfig_capable_o = 1'b0;
    link_fsm_state_o = phylr_pkg::LS_XMIT_EIOS;
    link_event_o = '0;
  end
  // A full retrain request drops the link into Detect
  always @(posedge clk_i) begin
    if (full_retrain_request_i) begin
      link_fsm_state_o <= phylr_pkg::LS_DET_QUIET;
    end
  end
  task automatic set_lines(input logic u, input logic [4:0] s);
    @(posedge clk_i);
    partner_upconfig_capable_o <= u;
    link_fsm_state_o <= s;
  endtask
  // Events last exactly one cycle, as the core reports them
  task automatic pulse(input phylr_pkg::phylr_event_type ev);
    @(posedge clk_i);
    link_event_o <= ev;
    @(posedge clk_i);
    link_event_o <= '0;
  endtask
endmodule

// ==== sim/phylr_regs_props.sv ====
// Port checks for the link state and reliability register bank.
// Assumes the zero-wait APB slave as built; rst_i silences every check.
`timescale 1ns/100ps
module phylr_regs_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hot_reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic partner_upconfig_capable_i,
  input wire logic [4:0] link_fsm_state_i,
  input wire logic prbs_advance_i,
  input wire logic full_retrain_request_o,
  input wire logic [15:0] prbs_state_o,
  input wire logic reliability_enable_o,
  input wire logic reliability_error_type_o,
  input wire logic unreliable_link_flag_o
);
  wire logic wr = psel_i && penable_i && pwrite_i;
  wire logic rds = psel_i && !penable_i && !pwrite_i;
  wire logic rd_state = rds && paddr_i == phylr_pkg::OFS_LINK_STATE;
  wire logic rd_part = rds && paddr_i == phylr_pkg::OFS_PARTNER_STATUS;
  wire logic wr_state = wr && paddr_i == phylr_pkg::OFS_LINK_STATE;
  wire logic wr_ctrl = wr && paddr_i == phylr_pkg::OFS_REL_CONTROL;
  wire logic wr_seed = wr && paddr_i == phylr_pkg::OFS_PRBS_SEED;
  wire logic wr_flag = wr && paddr_i == phylr_pkg::OFS_REL_STATUS;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  retrain_pulse_a: assert property (wr_state && pwdata_i[31]
    |=> full_retrain_request_o) else $error("retrain pulse missing");
  retrain_cause_a: assert property (full_retrain_request_o
    |-> $past(wr_state) && $past(pwdata_i[31]))
    else $error("retrain without write");
  state_read_a: assert property (rd_state |=>
    prdata_o == {27'h0, $past(link_fsm_state_i, 2)})
    else $error("bad state read");
  upcfg_read_a: assert property (rd_part |=>
    prdata_o == {15'h0, $past(partner_upconfig_capable_i, 2), 16'h0})
    else $error("bad partner read");
  ctrl_write_a: assert property (wr_ctrl |=>
    reliability_enable_o == $past(pwdata_i[0]) &&
    reliability_error_type_o == $past(pwdata_i[1]))
    else $error("control not written");
  flag_sticky_a: assert property (unreliable_link_flag_o && !wr_flag
    |=> unreliable_link_flag_o) else $error("flag cleared by hardware");
  flag_gated_a: assert property (!reliability_enable_o
    && !unreliable_link_flag_o |=> !unreliable_link_flag_o)
    else $error("flag set while disabled");
  prbs_hold_a: assert property (!prbs_advance_i && !wr_seed
    |=> $stable(prbs_state_o)) else $error("prbs moved");
  hot_keep_a: assert property (hot_reset_i && !wr_ctrl |=>
    $stable(reliability_enable_o) && $stable(reliability_error_type_o))
    else $error("sticky control lost");
endmodule
////////////////////////////////////////////////////////////////////////////
bind phylr_regs phylr_regs_props i_props (.clk_i(clk_i), .rst_i(rst_i),
  .hot_reset_i(hot_reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .partner_upconfig_capable_i(partner_upconfig_capable_i),
  .link_fsm_state_i(link_fsm_state_i), .prbs_advance_i(prbs_advance_i),
  .full_retrain_request_o(full_retrain_request_o),
  .prbs_state_o(prbs_state_o), .reliability_enable_o(reliability_enable_o),
  .reliability_error_type_o(reliability_error_type_o),
  .unreliable_link_flag_o(unreliable_link_flag_o));

// ==== sim/test_phylr_regs.sv ====
// Self-checking bench for the link state and reliability register bank.
// Assumes the core stand-in model drives the port core inputs except prbs_advance_i, which the bench drives.
`timescale 1ns/100ps
module test_phylr_regs;
  logic clk_i, rst_i, hot_reset_i, psel_i, penable_i, pwrite_i, adv;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, err, frr, upc, en_o, typ_o, flag_o, irq_o;
  logic prbs_bit_o;
  logic [4:0] lfs;
  logic [15:0] prbs_o, s;
  phylr_pkg::phylr_event_type ev;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  phylr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .hot_reset_i(hot_reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .partner_upconfig_capable_i(upc), .link_fsm_state_i(lfs),
    .link_event_i(ev), .prbs_advance_i(adv),
    .full_retrain_request_o(frr), .prbs_state_o(prbs_o),
    .prbs_bit_o(prbs_bit_o), .reliability_enable_o(en_o),
    .reliability_error_type_o(typ_o), .unreliable_link_flag_o(flag_o),
    .irq_o(irq_o));
  phylr_core_model i_core (.clk_i(clk_i), .full_retrain_request_i(frr),
    .partner_upconfig_capable_o(upc), .link_fsm_state_o(lfs),
    .link_event_o(ev));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // A hung handshake would never return, so cycles are capped
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic hot_rst;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      hot_reset_i <= (k == 0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(phylr_pkg::OFS_LINK_STATE, 32'h0);
    rdc(phylr_pkg::OFS_PRBS_SEED, 32'h0000ffff);
    rdc(phylr_pkg::OFS_REL_CONTROL, 32'h0);
    apb(1'b0, 12'h600, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_state;
    for (int i = 0; i < 29; i++) begin
      i_core.set_lines(i[0], i[4:0]);
      rdc(phylr_pkg::OFS_PARTNER_STATUS, {15'h0, i[0], 16'h0});
      rdc(phylr_pkg::OFS_LINK_STATE, {27'h0, i[4:0]});
    end
    apb(1'b1, phylr_pkg::OFS_PARTNER_STATUS, 32'hffff_ffff);
    rdc(phylr_pkg::OFS_PARTNER_STATUS, 32'h0);
  endtask
  task automatic t_retrain;
    apb(1'b1, phylr_pkg::OFS_IRQ_MASK, 32'h4);
    apb(1'b1, phylr_pkg::OFS_LINK_STATE, 32'h8000_0000);
    chk("retrain at completion", 32'h0, {31'h0, frr});
    @(posedge clk_i);
    chk("retrain pulse", 32'h1, {31'h0, frr});
    #1 chk("irq raised", 32'h1, {31'h0, irq_o});
    rdc(phylr_pkg::OFS_LINK_STATE, {27'h0, phylr_pkg::LS_DET_QUIET});
    rdc(phylr_pkg::OFS_IRQ_STATUS, 32'h4);
    #1 chk("irq cleared", 32'h0, {31'h0, irq_o});
    apb(1'b1, phylr_pkg::OFS_IRQ_MASK, 32'h0);
    apb(1'b1, phylr_pkg::OFS_LINK_STATE, 32'h8000_0000);
    repeat (3) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rdc(phylr_pkg::OFS_IRQ_STATUS, 32'h4);
  endtask
  task automatic t_seed;
    apb(1'b1, phylr_pkg::OFS_PRBS_SEED, 32'hffff_1234);
    rdc(phylr_pkg::OFS_PRBS_SEED, 32'h0000_1234);
    chk("prbs reload", 32'h1234, {16'h0, prbs_o});
    s = 16'h1234;
    repeat (3) s = {s[14:0], ^(s & phylr_pkg::PRBS_TAPS) ^ s[15]};
    // Three steps so the taps, not only the shift, are exercised
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      adv <= (k < 3);
    end
    hot_rst();
    rdc(phylr_pkg::OFS_PRBS_SEED, 32'h0000_1234);
    chk("prbs step", {16'h0, s}, {16'h0, prbs_o});
    chk("prbs bit", {31'h0, s[15]}, {31'h0, prbs_bit_o});
  endtask
  task automatic t_rel;
    apb(1'b1, phylr_pkg::OFS_REL_THRESHOLD, 32'h2);
    repeat (2) i_core.pulse(5'b10000);
    repeat (2) @(posedge clk_i);
    chk("flag disabled", 32'h0, {31'h0, flag_o});
    apb(1'b1, phylr_pkg::OFS_REL_CONTROL, 32'h1);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h0);
    repeat (2) i_core.pulse(5'b10000);
    repeat (2) @(posedge clk_i);
    chk("flag set", 32'h1, {31'h0, flag_o});
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h2);
    apb(1'b1, phylr_pkg::OFS_REL_CONTROL, 32'h3);
    i_core.pulse(5'b01000);
    i_core.pulse(5'b10000);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h2);
    i_core.pulse(5'b01100);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h3);
    apb(1'b1, phylr_pkg::OFS_REL_CONTROL, 32'h0);
    apb(1'b1, phylr_pkg::OFS_REL_CONTROL, 32'h1);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h0);
    repeat (258) i_core.pulse(5'b10000);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'hff);
    rdc(phylr_pkg::OFS_IRQ_STATUS, 32'h1);
    // Link down lands in the setup cycle of a status read
    fork
      rdc(phylr_pkg::OFS_IRQ_STATUS, 32'h0);
      i_core.pulse(5'b00010);
    join
    rdc(phylr_pkg::OFS_IRQ_STATUS, 32'h2);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h0);
    i_core.pulse(5'b10000);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h1);
    i_core.pulse(5'b00001);
    rdc(phylr_pkg::OFS_REL_COUNT, 32'h0);
    hot_rst();
    rdc(phylr_pkg::OFS_REL_CONTROL, 32'h1);
    chk("flag kept", 32'h1, {31'h0, flag_o});
    apb(1'b1, phylr_pkg::OFS_REL_STATUS, 32'h1);
    rdc(phylr_pkg::OFS_REL_STATUS, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    hot_reset_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h0;
    pwdata_i = 32'h0;
    adv = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_state();
    t_retrain();
    t_seed();
    t_rel();
    tally_and_finish();
  end
endmodule
